/* verilog/acsrf_top.sv */
/*
 Converter channel/reference selection and result formatting. Holds the
 selection register, defers changes across a running conversion, formats
 raw samples for single-ended, unipolar and bipolar conversions and
 presents them through the low and high result registers.
 Assumes a converter core on the same clock that pulses conv_start and
 later sample_valid with a signed raw code scaled as difference * 1024 /
 reference * gain, saturated to 12 bits.
*/
`timescale 1ns/100ps
`include "acsrf_defines.svh"

// Notes on behaviour
// RULE1: result readable in registers after completion
// RULE2: single-ended gives unsigned 10-bit code
// RULE3: unipolar differential saturates negatives to zero
// RULE4: bipolar gives two's complement 0x200..0x1FF
// RULE5: bipolar top bit is the sign
// RULE6: unipolar by default, bipolar when bit set
// RULE7: reference change waits for conversion end
// RULE8: channel change waits for conversion end
// RULE9: reference field decodes to four sources
// RULE10: codes 0..7 select single inputs
// RULE11: codes 20..22 select ground, reference, temperature
// RULE12: code ranges give pairs, reversed, calibration
// RULE13: lowest bit selects 1x or 20x
// RULE14: top bit reverses pair polarity
// RULE15: calibration ties one pin to both inputs
// RULE16: pairs decode from the pair table
// RULE17: select register fields, all zero at reset
// RULE18: software discards results while settling
// RULE19: right adjusted unless left adjust set
// RULE20: low read locks updates until high read
// RULE21: pending selection latches at completion or idle
module acsrf_top (
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] address, // Register address
    input wire logic [7:0] write_data, // Register write data
    input wire logic write_strobe, // One-cycle write
    input wire logic read_strobe, // One-cycle read
    output logic [7:0] read_data, // Valid the cycle after read_strobe
    input wire logic conv_start, // Converter core starts sampling
    input wire logic sample_valid, // Converter core finished
    input wire logic signed [11:0] sample_code, // Raw signed sample
    output logic ref_supply_sel, // Supply used as reference
    output logic ref_external_sel, // External reference pin used
    output logic ref_internal_en, // Internal 1.1V reference on
    output logic ref_pin_drive, // Internal reference driven to pin
    output logic [3:0] pos_input_sel, // Positive input selector
    output logic [3:0] neg_input_sel, // Negative input selector
    output logic diff_mode, // Differential selection active
    output logic gain_20x, // 20x gain selected
    output logic temp_sense_en, // Temperature sensor enabled
    output logic busy // Conversion in progress
);
    // Software-visible registers
    logic [7:0] select_reg; // Pending selection, RW
    logic [7:0] ctrl_b_reg; // Bipolar and left adjust, RW
    logic done_reg; // Completion flag, write one to clear
    logic [9:0] result_reg; // Formatted result
    logic lock_reg; // Set by low read, cleared by high read
    logic [7:0] active_reg; // Selection the converter really uses
    logic [7:0] read_data_reg;
    logic [1:0] ref_act_reg; // Decoded reference outputs source
    logic ref_supply_reg, ref_ext_reg, ref_int_reg, ref_drive_reg;
    acsrf_pkg::acsrf_conv_state_t state_reg, state_next;

    // Address decode
    wire sel_hit = address == `ACSRF_OFS_SELECT;
    wire ctrl_hit = address == `ACSRF_OFS_CTRL_B;
    wire stat_hit = address == `ACSRF_OFS_STATUS;
    wire low_hit = address == `ACSRF_OFS_RES_LOW;
    wire high_hit = address == `ACSRF_OFS_RES_HIGH;
    wire sel_wr = write_strobe && sel_hit;
    wire ctrl_wr = write_strobe && ctrl_hit;
    wire done_clr = write_strobe && stat_hit &&
                    write_data[`ACSRF_BIT_DONE];
    wire low_rd = read_strobe && low_hit;
    wire high_rd = read_strobe && high_hit;

    wire bipolar = ctrl_b_reg[`ACSRF_BIT_BIPOLAR];
    wire left_adj = ctrl_b_reg[`ACSRF_BIT_LADJ];
    wire is_diff; // Differential selection from the table
    wire conv_busy = state_reg == acsrf_pkg::ACSRF_CONVERTING;

    // Tracking of the running conversion
    // A start seen while converting is ignored: the core never overlaps
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            acsrf_pkg::ACSRF_IDLE: begin
                if (conv_start) begin
                    state_next = acsrf_pkg::ACSRF_CONVERTING;
                end
            end
            acsrf_pkg::ACSRF_CONVERTING: begin
                if (sample_valid) begin
                    state_next = acsrf_pkg::ACSRF_IDLE;
                end
            end
        endcase
    end

    // Selection follows the pending value while idle and is frozen
    // during a conversion; completion reopens it in the same edge
    wire act_load = !conv_busy || sample_valid; // RULE21 RULE7 RULE8
    wire [7:0] active_next = act_load ? select_reg : active_reg;
    wire [1:0] ref_code = active_reg[`ACSRF_REF_MSB:`ACSRF_REF_LSB];

    // Result saturation per conversion type
    wire neg_raw = sample_code[11];
    wire over_u = !neg_raw && sample_code[10]; // Above 1023
    wire [9:0] uni_code = neg_raw ? 10'h000 :
                          over_u ? `ACSRF_UMAX :
                          sample_code[9:0]; // RULE2 RULE3
    // Halving gives the 512 scale; clamp to -512..+511
    wire [10:0] half = sample_code[11:1];
    wire bip_hi = !half[10] && half[9];
    wire bip_lo = half[10] && !half[9];
    wire [9:0] bip_code = bip_hi ? `ACSRF_BMAX :
                          bip_lo ? `ACSRF_BMIN :
                          {half[10], half[8:0]}; // RULE4 RULE5
    // Single-ended ignores the bipolar bit; it only applies to differential selections
    wire [9:0] fmt_code = (is_diff && bipolar) ? bip_code : uni_code;
    // Update only when the register pair is not locked by a low read
    wire res_load = sample_valid && !lock_reg; // RULE20

    // Right or left adjusted views, applied at read time so the bit
    // takes effect at once regardless of a running conversion
    wire [7:0] res_high = left_adj ? result_reg[9:2] :
                          {6'h00, result_reg[9:8]}; // RULE19
    wire [7:0] res_low = left_adj ? {result_reg[1:0], 6'h00} :
                         result_reg[7:0]; // RULE19
    wire [7:0] status_val = ({7'h00, done_reg} << `ACSRF_BIT_DONE) |
                            ({7'h00, conv_busy} << `ACSRF_BIT_BUSY);
    // Unmapped addresses read as zero
    wire [7:0] read_mux = sel_hit ? select_reg :
                          ctrl_hit ? ctrl_b_reg :
                          stat_hit ? status_val :
                          low_hit ? res_low :
                          high_hit ? res_high : 8'h00;

    // Reference decode, registered so outputs come from flops
    // Decoded from the active copy so a pending write never glitches it
    wire ref_sup_n = ref_code == `ACSRF_REF_SUPPLY; // RULE9
    wire ref_ext_n = ref_code == `ACSRF_REF_EXT;
    wire ref_int_n = ref_code[1]; // Both internal codes
    wire ref_drv_n = ref_code == `ACSRF_REF_INT_PIN;

    // Software registers; fields reset to zero
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            select_reg <= `ACSRF_RST_SELECT; // RULE17
            ctrl_b_reg <= `ACSRF_RST_CTRL_B; // RULE6
        end else begin
            if (sel_wr) begin
                select_reg <= write_data; // RULE17
            end
            if (ctrl_wr) begin
                ctrl_b_reg <= write_data; // RULE6
            end
        end
    end

    // Completion flag: a completion in the clearing cycle wins
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= sample_valid || (done_reg && !done_clr); // RULE1
        end
    end

    // Result and its read lock; a completion in the high-read cycle is still blocked
    // The lock keeps software from mixing bytes of two samples
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            result_reg <= 10'h000;
            lock_reg <= 1'b0;
        end else begin
            if (res_load) begin
                result_reg <= fmt_code; // RULE1
            end
            if (high_rd) begin
                lock_reg <= 1'b0; // RULE20
            end else if (low_rd) begin
                lock_reg <= 1'b1; // RULE20
            end
        end
    end

    // Active selection, tracking state and registered outputs
    // Reset leaves the supply selected, matching an all-zero field
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= acsrf_pkg::ACSRF_IDLE;
            active_reg <= `ACSRF_RST_SELECT;
            read_data_reg <= 8'h00;
            ref_supply_reg <= 1'b1;
            ref_ext_reg <= 1'b0;
            ref_int_reg <= 1'b0;
            ref_drive_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            active_reg <= active_next;
            read_data_reg <= read_strobe ? read_mux : 8'h00;
            ref_supply_reg <= ref_sup_n;
            ref_ext_reg <= ref_ext_n;
            ref_int_reg <= ref_int_n;
            ref_drive_reg <= ref_drv_n;
        end
    end

    // Channel table lookup with registered outputs
    acsrf_chan_rom acsrf_chan_rom_inst (
        .clock(clock),
        .reset(reset),
        .channel_code(active_reg[`ACSRF_CH_MSB:0]),
        .pos_sel_reg(pos_input_sel),
        .neg_sel_reg(neg_input_sel),
        .diff_reg(is_diff),
        .gain_reg(gain_20x),
        .temp_reg(temp_sense_en)
    );

    assign diff_mode = is_diff;
    // Read data falls back to zero so a stale byte never looks fresh
    assign read_data = read_data_reg;
    assign ref_supply_sel = ref_supply_reg;
    assign ref_external_sel = ref_ext_reg;
    assign ref_internal_en = ref_int_reg;
    assign ref_pin_drive = ref_drive_reg;
    // Busy is the tracking flop itself, with no extra stage
    assign busy = state_reg == acsrf_pkg::ACSRF_CONVERTING;
    assign ref_act_reg = ref_code;

    // Checks on the deferral, formatting and register views
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // A conversion held open: busy and not finishing this cycle
    sequence s_conv_hold;
        conv_busy && !sample_valid;
    endsequence

    sequence s_conv_end;
        conv_busy ##1 sample_valid;
    endsequence

    a_ref_frozen: assert property ( // RULE7
        s_conv_hold |=> $stable(active_reg[7:6]))
        else $error("reference changed during conversion");
    a_chan_frozen: assert property ( // RULE8
        s_conv_hold |=> $stable(active_reg[5:0]))
        else $error("channel changed during conversion");
    a_end_latch: assert property ( // RULE21
        s_conv_end |=> active_reg == $past(select_reg))
        else $error("pending selection not taken at completion");
    a_idle_follow: assert property ( // RULE21
        !conv_busy ##1 !conv_busy |-> active_reg == $past(select_reg))
        else $error("idle selection not following register");
    a_single_floor: assert property ( // RULE2
        res_load && !is_diff && neg_raw |=> result_reg == 10'h000)
        else $error("single-ended negative not zero");
    a_uni_sat: assert property ( // RULE3
        res_load && !bipolar && over_u |=> result_reg == `ACSRF_UMAX)
        else $error("unipolar overrange not saturated");
    a_bip_sign: assert property ( // RULE5
        res_load && is_diff && bipolar |=> result_reg[9] == $past(neg_raw))
        else $error("bipolar sign bit wrong");
    a_lock_hold: assert property ( // RULE20
        lock_reg && !high_rd |=> $stable(result_reg))
        else $error("result changed while locked");
    a_done_set: assert property ( // RULE1
        sample_valid |=> done_reg ##1 (done_reg || $past(done_clr)))
        else $error("completion flag not set");
    a_ref_drive: assert property ( // RULE9
        ref_act_reg == `ACSRF_REF_INT_PIN |=> ref_pin_drive && ref_internal_en)
        else $error("internal reference not driven to pin");
    a_temp_sel: assert property ( // RULE11
        active_reg[5:0] == `ACSRF_CH_TEMP |=> temp_sense_en &&
        pos_input_sel == `ACSRF_SEL_TEMP)
        else $error("temperature input not selected");
    a_left_view: assert property ( // RULE19
        high_rd && left_adj |=> read_data == $past(result_reg[9:2]))
        else $error("left adjusted high byte wrong");

    // Clamp ends, gain bit and the lock handshake
    a_bip_clamp: assert property ( // RULE4
        res_load && is_diff && bipolar && bip_lo |=>
        result_reg == `ACSRF_BMIN)
        else $error("bipolar underrange not clamped");
    a_uni_floor: assert property ( // RULE3
        res_load && is_diff && !bipolar && neg_raw |=>
        result_reg == 10'h000)
        else $error("unipolar negative difference not zero");
    a_gain_follow: assert property ( // RULE13
        is_diff |-> gain_20x == $past(active_reg[0]))
        else $error("gain does not follow lowest channel bit");
    a_low_lock: assert property ( // RULE20
        low_rd |=> lock_reg)
        else $error("low read did not lock the result");
endmodule // acsrf_top

/* verilog/acsrf_defines.svh */
/*
 Register offsets, field positions, reset values and fixed codes of the
 converter channel select and result format block.
 Assumes inclusion by bare name from every file that needs the constants.
*/
`ifndef ACSRF_DEFINES_SVH
`define ACSRF_DEFINES_SVH

// Register offsets on the 8-bit register port
`define ACSRF_OFS_CTRL_B 8'h03
`define ACSRF_OFS_RES_LOW 8'h04
`define ACSRF_OFS_RES_HIGH 8'h05
`define ACSRF_OFS_STATUS 8'h06
`define ACSRF_OFS_SELECT 8'h07

// Field positions
`define ACSRF_REF_MSB 7
`define ACSRF_REF_LSB 6
`define ACSRF_CH_MSB 5
`define ACSRF_BIT_BIPOLAR 7
`define ACSRF_BIT_LADJ 4
`define ACSRF_BIT_DONE 4
`define ACSRF_BIT_BUSY 6

// Reset values
`define ACSRF_RST_SELECT 8'h00
`define ACSRF_RST_CTRL_B 8'h00

// Reference field codes
`define ACSRF_REF_SUPPLY 2'h0
`define ACSRF_REF_EXT 2'h1
`define ACSRF_REF_INT 2'h2
`define ACSRF_REF_INT_PIN 2'h3

// Input selector codes beyond pins 0..7
`define ACSRF_SEL_TEMP 4'h8
`define ACSRF_SEL_GND 4'h9
`define ACSRF_SEL_IREF 4'hA

// Special channel codes
`define ACSRF_CH_GND 6'h20
`define ACSRF_CH_IREF 6'h21
`define ACSRF_CH_TEMP 6'h22

// Result limits
`define ACSRF_UMAX 10'h3FF
`define ACSRF_BMAX 10'h1FF
`define ACSRF_BMIN 10'h200

`endif

/* verilog/acsrf_pkg.sv */
/*
 Types shared by the converter channel select and result format block.
 Assumes nothing of its surroundings.
*/
package acsrf_pkg;
    // Conversion tracking state
    typedef enum logic {
        ACSRF_IDLE,
        ACSRF_CONVERTING
    } acsrf_conv_state_t;
endpackage

/* verilog/acsrf_chan_rom.sv */
/*
 Channel code decode table: maps the active 6-bit channel code to the
 positive and negative input selectors, gain and temperature enable.
 Assumes a registered channel code on the same clock; outputs are
 registered, so they follow the code one clock later.
*/
`timescale 1ns/100ps
`include "acsrf_defines.svh"

module acsrf_chan_rom (
    input wire logic clock,
    input wire logic reset,
    input wire logic [5:0] channel_code,
    output logic [3:0] pos_sel_reg,
    output logic [3:0] neg_sel_reg,
    output logic diff_reg,
    output logic gain_reg,
    output logic temp_reg
);
    // Pair table by code bits 4:1, positive pin then negative pin
    function automatic logic [5:0] pair_lookup(input logic [3:0] idx);
        unique case (idx)
            4'h4: pair_lookup = {3'h0, 3'h1};
            4'h5: pair_lookup = {3'h0, 3'h3};
            4'h6: pair_lookup = {3'h1, 3'h2};
            4'h7: pair_lookup = {3'h1, 3'h3};
            4'h8: pair_lookup = {3'h2, 3'h3};
            4'h9: pair_lookup = {3'h3, 3'h4};
            4'hA: pair_lookup = {3'h3, 3'h5};
            4'hB: pair_lookup = {3'h3, 3'h6};
            4'hC: pair_lookup = {3'h3, 3'h7};
            4'hD: pair_lookup = {3'h4, 3'h5};
            4'hE: pair_lookup = {3'h5, 3'h6};
            4'hF: pair_lookup = {3'h6, 3'h7};
            // Indices 0..3 never reach here as pairs
            default: pair_lookup = {3'h0, 3'h0};
        endcase
    endfunction

    wire [5:0] pair = pair_lookup(channel_code[4:1]); // RULE16
    // Pairs live wherever bits 4:3 are non-zero
    wire is_pair = channel_code[4:3] != 2'h0; // RULE12
    // Offset calibration: 100011..100111
    wire is_cal = channel_code[5:3] == 3'h4 && channel_code[2:0] > 3'h2;
    // Calibration pins 0, 3 and 7 chosen by bits 2:1
    wire [2:0] cal_pin = channel_code[2:1] == 2'h1 ? 3'h0 :
                         channel_code[2:1] == 2'h2 ? 3'h3 : 3'h7; // RULE15
    wire [3:0] pin_p = {1'b0, pair[5:3]};
    wire [3:0] pin_n = {1'b0, pair[2:0]};
    // Special inputs for 100000..100010
    wire [3:0] spec_sel = channel_code == `ACSRF_CH_GND ? `ACSRF_SEL_GND :
                          channel_code == `ACSRF_CH_IREF ? `ACSRF_SEL_IREF :
                          `ACSRF_SEL_TEMP; // RULE11
    // Top bit swaps the pair polarity
    wire [3:0] pos_next = is_pair ? (channel_code[5] ? pin_n : pin_p) :
                          is_cal ? {1'b0, cal_pin} :
                          !channel_code[5] ? {1'b0, channel_code[2:0]} :
                          spec_sel; // RULE14 RULE10
    wire [3:0] neg_next = is_pair ? (channel_code[5] ? pin_p : pin_n) :
                          is_cal ? {1'b0, cal_pin} : `ACSRF_SEL_GND;
    wire diff_next = is_pair || is_cal;
    // Lowest bit picks 20x for differential selections
    wire gain_next = diff_next && channel_code[0]; // RULE13
    wire temp_next = channel_code == `ACSRF_CH_TEMP; // RULE11

    // Registered table output
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pos_sel_reg <= 4'h0;
            neg_sel_reg <= `ACSRF_SEL_GND;
            diff_reg <= 1'b0;
            gain_reg <= 1'b0;
            temp_reg <= 1'b0;
        end else begin
            pos_sel_reg <= pos_next;
            neg_sel_reg <= neg_next;
            diff_reg <= diff_next;
            gain_reg <= gain_next;
            temp_reg <= temp_next;
        end
    end
endmodule // acsrf_chan_rom

/* verification/acsrf_conv_model.sv */
/*
 Behavioural converter core standing behind the select and format block.
 Assumes the bench asks for one conversion at a time through go.
*/
`timescale 1ns/100ps

module acsrf_conv_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic go, // Request one conversion
    input wire logic signed [11:0] raw, // Code reported at completion
    input wire logic [3:0] wait_len, // Countdown cycles; completion comes wait_len + 1 cycles after the start
    output logic conv_start,
    output logic sample_valid,
    output logic signed [11:0] sample_code,
    output logic idle // No conversion running
);
    logic [3:0] cnt; // Cycles left in the running conversion

    // Start pulse, countdown, then one completion pulse with the code
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            conv_start <= 1'b0;
            sample_valid <= 1'b0;
            sample_code <= 12'h000;
            idle <= 1'b1;
            cnt <= 4'h0;
        end else begin
            conv_start <= go && idle;
            sample_valid <= 1'b0;
            // Code means nothing off the completion cycle, so it churns
            sample_code <= ~sample_code;
            if (go && idle) begin
                idle <= 1'b0;
                cnt <= wait_len;
            end else if (!idle) begin
                if (cnt == 4'h0) begin
                    sample_valid <= 1'b1;
                    sample_code <= raw;
                    idle <= 1'b1;
                end else begin
                    cnt <= cnt - 4'h1;
                end
            end
        end
    end
endmodule // acsrf_conv_model

/* verification/tb_acsrf_top.sv */
/*
 Self-checking bench for the select and format block.
 Assumes the converter model is compiled beside it.
*/
`timescale 1ns/100ps

module tb_acsrf_top;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] address = 8'h00;
    logic [7:0] write_data = 8'h00;
    logic write_strobe = 1'b0;
    logic read_strobe = 1'b0;
    logic go = 1'b0; // Conversion request to the model
    logic signed [11:0] raw = 12'h000; // Code the model reports
    logic [3:0] wait_len = 4'h0; // Model conversion length
    logic [7:0] read_data, lo, hi, st;
    logic signed [11:0] sample_code;
    logic conv_start, sample_valid, idle, busy;
    logic ref_supply_sel, ref_external_sel, ref_internal_en, ref_pin_drive;
    logic diff_mode, gain_20x, temp_sense_en;
    logic [3:0] pos_input_sel, neg_input_sel;
    int fail_count = 0;
    int n_compared = 0;
    // Expected reference outputs per field code
    localparam logic [3:0] REF_EXP [4] = '{4'h8, 4'h4, 4'h2, 4'h3};
    // Selection outputs packed so one compare covers them all
    wire logic [15:0] pins = {ref_supply_sel, ref_external_sel,
        ref_internal_en, ref_pin_drive, pos_input_sel, neg_input_sel,
        diff_mode, gain_20x, temp_sense_en, busy};

    // Free-running 25 MHz clock
    always #20 clock = ~clock;

    acsrf_top acsrf_top_inst (.clock, .reset, .address, .write_data,
        .write_strobe, .read_strobe, .read_data, .conv_start,
        .sample_valid, .sample_code, .ref_supply_sel, .ref_external_sel,
        .ref_internal_en, .ref_pin_drive, .pos_input_sel, .neg_input_sel,
        .diff_mode, .gain_20x, .temp_sense_en, .busy);
    acsrf_conv_model acsrf_conv_model_inst (.clock, .reset, .go, .raw,
        .wait_len, .conv_start, .sample_valid, .sample_code, .idle);

    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk_byte(input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task chk_word(input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // One-cycle write strobe
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1;
        d = read_data;
    endtask

    task start_conv(input logic [11:0] r, input logic [3:0] w);
        @(posedge clock);
        raw <= r;
        wait_len <= w;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
    endtask

    task wait_done;
        int i;
        for (i = 0; i < 40 && sample_valid !== 1'b1; i++) @(posedge clock);
        if (i == 40) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time,
                sample_valid, 1'b1);
            finish_test;
        end
    endtask

    task conv(input logic [11:0] r);
        start_conv(r, 4'h0);
        wait_done;
    endtask

    // Table outputs follow a write two clocks later when idle
    task chk_sel(input logic [5:0] c, input logic [7:0] pn,
        input logic [2:0] d);
        wr(8'h07, {2'b00, c});
        repeat (3) @(posedge clock);
        #1;
        chk_word({4'h8, pn, d, 1'b0}, pins);
    endtask

    // Run one conversion under a mode and check the 10-bit result
    task fmt(input logic [7:0] cb, input logic [7:0] sel,
        input logic [11:0] r, input logic [9:0] e);
        wr(8'h03, cb);
        wr(8'h07, sel);
        repeat (3) @(posedge clock);
        conv(r);
        rd(8'h04, lo);
        rd(8'h05, hi);
        chk_word({6'h00, e}, {6'h00, hi[1:0], lo});
    endtask

    task s_reset;
        rd(8'h07, st);
        chk_byte(8'h00, st);
        @(posedge clock);
        #1;
        chk_byte(8'h00, read_data);
        rd(8'h03, st);
        chk_byte(8'h00, st);
        rd(8'h10, st);
        chk_byte(8'h00, st);
        chk_word(16'h8090, pins);
    endtask

    task s_rw;
        wr(8'h07, 8'hC5);
        rd(8'h07, st);
        chk_byte(8'hC5, st);
        wr(8'h04, 8'hFF);
        rd(8'h04, st);
        chk_byte(8'h00, st);
        rd(8'h05, st);
        chk_byte(8'h00, st);
    endtask

    task s_ref;
        for (int r = 0; r < 4; r++) begin
            wr(8'h07, {r[1:0], 6'h00});
            repeat (3) @(posedge clock);
            #1;
            chk_word({12'h000, REF_EXP[r]}, {12'h000, pins[15:12]});
        end
    endtask

    task s_chan;
        chk_sel(6'h00, 8'h09, 3'b000);
        chk_sel(6'h07, 8'h79, 3'b000);
        chk_sel(6'h20, 8'h99, 3'b000);
        chk_sel(6'h21, 8'hA9, 3'b000);
        chk_sel(6'h22, 8'h89, 3'b001);
        chk_sel(6'h08, 8'h01, 3'b100);
        chk_sel(6'h09, 8'h01, 3'b110);
        chk_sel(6'h28, 8'h10, 3'b100);
        chk_sel(6'h2A, 8'h30, 3'b100);
        chk_sel(6'h12, 8'h34, 3'b100);
        chk_sel(6'h1F, 8'h67, 3'b110);
        chk_sel(6'h3F, 8'h76, 3'b110);
        chk_sel(6'h23, 8'h00, 3'b110);
        chk_sel(6'h24, 8'h33, 3'b100);
        chk_sel(6'h27, 8'h77, 3'b110);
    endtask

    // Selection written mid-conversion waits for completion
    task s_defer;
        chk_sel(6'h00, 8'h09, 3'b000);
        start_conv(12'h000, 4'hC);
        wr(8'h07, 8'hC9);
        repeat (3) @(posedge clock);
        #1;
        chk_word(16'h8091, pins);
        rd(8'h07, st);
        chk_byte(8'hC9, st);
        wait_done;
        repeat (3) @(posedge clock);
        #1;
        chk_word(16'h301C, pins);
    endtask

    task s_format;
        fmt(8'h00, 8'h00, 12'h155, 10'h155);
        fmt(8'h00, 8'h00, 12'h7FF, 10'h3FF);
        fmt(8'h00, 8'h00, 12'hFFB, 10'h000);
        fmt(8'h00, 8'h08, 12'hF9C, 10'h000);
        fmt(8'h00, 8'h09, 12'h200, 10'h200);
        fmt(8'h80, 8'h08, 12'hC00, 10'h200);
        fmt(8'h80, 8'h08, 12'h7D0, 10'h1FF);
        fmt(8'h80, 8'h08, 12'h800, 10'h200);
        fmt(8'h80, 8'h28, 12'hFFE, 10'h3FF);
        fmt(8'h80, 8'h08, 12'h100, 10'h080);
        fmt(8'h80, 8'h00, 12'hFFB, 10'h000);
        fmt(8'h00, 8'h00, 12'h155, 10'h155);
        wr(8'h03, 8'h10);
        rd(8'h04, lo);
        rd(8'h05, hi);
        chk_word(16'h5540, {hi, lo});
        wr(8'h03, 8'h00);
    endtask

    // Low read holds the result until the high byte is read
    task s_lock;
        wr(8'h06, 8'h10);
        rd(8'h04, lo);
        conv(12'h0AA);
        rd(8'h06, st);
        chk_byte(8'h10, st & 8'h50);
        rd(8'h05, hi);
        chk_byte(8'h01, hi);
        rd(8'h04, lo);
        rd(8'h05, hi);
        chk_word(16'h0155, {hi, lo});
        wr(8'h06, 8'h10);
        rd(8'h06, st);
        chk_byte(8'h00, st & 8'h10);
        conv(12'h0AA);
        rd(8'h04, lo);
        rd(8'h05, hi);
        chk_word(16'h00AA, {hi, lo});
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        s_reset;
        s_rw;
        s_ref;
        s_chan;
        s_defer;
        s_format;
        s_lock;
        finish_test;
    end
endmodule // tb_acsrf_top
